//--- dv/pwm_block_assertions.sv
// Purpose: bus-side checks on the four-channel pwm block
// Assumes: zero-wait slave, read data in the data phase
// Notes: the interrupt mask is rebuilt here from observed bus writes
`timescale 1ns/10ps
module pwm_block_assertions
    import pwm_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // waveform and interrupt
    input wire logic [NUM_CH-1:0] pwm_out,
    input wire logic irq
);
    // ====
    // bus tracking
    logic take;
    logic rd_q, wr_q;
    logic [11:0] addr_q;
    logic [3:0] mask_q, mask_d, exp_q;
    assign take = hsel & hready & htrans[1];
    assign mask_d = !wr_q ? mask_q : (addr_q == OFF_IER) ? (mask_q | hwdata[3:0]) :
        (addr_q == OFF_IDR) ? (mask_q & ~hwdata[3:0]) : mask_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 12'h000;
            mask_q <= 4'h0;
            exp_q <= 4'h0;
        end else begin
            rd_q <= take & ~hwrite;
            wr_q <= take & hwrite;
            addr_q <= take ? haddr : addr_q;
            mask_q <= mask_d;
            // read data is sampled at the address edge, before a pending write lands
            exp_q <= take ? mask_q : exp_q;
        end
    end
    // ====
    // properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_ready_always: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("error response seen");
    a_mask_readback: assert property (rd_q && addr_q == OFF_IMR |-> hrdata[3:0] == exp_q)
        else $error("mask read differs from bus history");
    a_flag_reserved: assert property (rd_q && (addr_q == OFF_IMR || addr_q == OFF_ISR)
        |-> hrdata[31:4] == 28'h0) else $error("reserved flag bits set");
    a_count_width: assert property (rd_q && addr_q[11:7] == 5'h04 && addr_q[4:2] == CH_COUNT
        |-> hrdata[31:16] == 16'h0000) else $error("counter wider than 16 bits");
    a_unmapped_zero: assert property (rd_q && addr_q[11:8] == 4'h1 |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!rd_q |-> $stable(hrdata)) else $error("hrdata moved");
    a_irq_masked: assert property (irq |-> ($past(mask_q) | $past(mask_q, 2)) != 4'h0)
        else $error("irq with all channels masked");
endmodule

bind pwm_block pwm_block_assertions pwm_block_assertions_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwm_out(pwm_out), .irq(irq)
);

//--- dv/pwm_block_tb.sv
// Purpose: self-checking bench for the four-channel pwm block
// Assumes: 20 MHz hclk, zero-wait slave
// Notes: pwm_out and irq are sampled on the falling edge, clear of the launch edge
`timescale 1ns/10ps
module pwm_block_tb
    import pwm_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic hwrite = 1'b0;
    logic hready;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp, irq;
    logic [NUM_CH-1:0] pwm_out;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    always #25 hclk = ~hclk;
    assign hready = hreadyout;
    pwm_block pwm_block_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_out(pwm_out), .irq(irq));
    // ====
    // helpers
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    // one idle cycle leads every transfer, so a read always sees the last write
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(n, e, rd);
    endtask
    function automatic logic [11:0] ca(input int ch, input logic [2:0] r);
        return OFF_CH_BASE + 12'(ch * 32) + {7'h00, r, 2'b00};
    endfunction
    function automatic logic [31:0] md(input logic [3:0] s, input logic a, input logic p,
        input logic t);
        return {21'h0, t, p, a, 4'h0, s};
    endfunction
    task automatic cfg(input int ch, input logic [31:0] m, input int p, input int d);
        bus(1'b1, ca(ch, CH_MODE), m);
        bus(1'b1, ca(ch, CH_PERIOD), 32'(p));
        bus(1'b1, ca(ch, CH_DUTY), 32'(d));
        bus(1'b1, OFF_ENA, 32'(1 << ch));
    endtask
    task automatic wait_lvl(input int ch, input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (pwm_out[ch] !== lvl && n < 3000);
    endtask
    task automatic measure(input int ch, input int et, input int eh);
        int n;
        int h;
        int l;
        wait_lvl(ch, 1'b0, n);
        wait_lvl(ch, 1'b1, n);
        wait_lvl(ch, 1'b0, h);
        wait_lvl(ch, 1'b1, l);
        check("high time", 32'(eh), 32'(h));
        check("period", 32'(et), 32'(h + l));
    endtask
    // ====
    // scenarios
    task automatic t_regs();
        rchk("mode", ca(1, CH_MODE), 32'h0);
        rchk("count", ca(1, CH_COUNT), 32'h0);
        rchk("unmapped", 12'h104, 32'h0);
        bus(1'b1, ca(1, CH_PERIOD), 32'h0000_1234);
        rchk("period", ca(1, CH_PERIOD), 32'h0000_1234);
        bus(1'b1, ca(1, CH_COUNT), 32'h0000_0055);
        rchk("count ro", ca(1, CH_COUNT), 32'h0);
        // reserved mode bits are written as ones and must read back as zero
        bus(1'b1, ca(1, CH_MODE), 32'hFFFF_FFFC);
        rchk("mode rw", ca(1, CH_MODE), 32'h0000_070C);
        @(negedge hclk);
        check("start high", 32'h1, 32'(pwm_out[1]));
        bus(1'b1, ca(1, CH_MODE), 32'h0);
        // the output flop follows the mode one cycle after the write lands
        repeat (2) @(negedge hclk);
        check("start low", 32'h0, 32'(pwm_out[1]));
        $display("test regs done");
    endtask
    task automatic t_mask();
        rchk("mask reset", OFF_IMR, 32'h0);
        bus(1'b1, OFF_IER, 32'h5);
        rchk("mask set", OFF_IMR, 32'h5);
        bus(1'b1, OFF_IER, 32'h2);
        rchk("mask or", OFF_IMR, 32'h7);
        bus(1'b1, OFF_IDR, 32'h1);
        rchk("mask clr", OFF_IMR, 32'h6);
        bus(1'b1, OFF_IMR, 32'hF);
        bus(1'b1, OFF_IDR, 32'h6);
        rchk("mask ro", OFF_IMR, 32'h0);
        $display("test mask done");
    endtask
    task automatic t_wave();
        logic [3:0] sel [5] = '{4'h0, 4'h1, 4'hB, 4'hC, 4'h0};
        int prd [5] = '{5, 5, 5, 5, 4};
        int tot [5] = '{5, 10, 15, 20, 8};
        int hi [5] = '{3, 6, 9, 12, 5};
        // divider a: /3 of the master clock, divider b: /2 of the /2 prescale
        bus(1'b1, OFF_CLK_DIV, 32'h0102_0003);
        for (int i = 0; i < 5; i++) begin
            cfg(i % NUM_CH, md(sel[i], i == 4, 1'b0, 1'b0), prd[i], 2);
            measure(i % NUM_CH, tot[i], hi[i]);
            bus(1'b1, OFF_DIS, 32'hF);
        end
        $display("test wave done");
    endtask
    task automatic t_update();
        cfg(0, md(4'h0, 1'b0, 1'b0, 1'b0), 200, 10);
        bus(1'b1, ca(0, CH_UPDATE), 32'h0000_0032);
        rchk("duty held", ca(0, CH_DUTY), 32'h0000_000A);
        repeat (220) @(posedge hclk);
        rchk("duty new", ca(0, CH_DUTY), 32'h0000_0032);
        bus(1'b1, ca(0, CH_MODE), md(4'h0, 1'b0, 1'b0, 1'b1));
        bus(1'b1, ca(0, CH_UPDATE), 32'hFFFF_0078);
        rchk("period held", ca(0, CH_PERIOD), 32'h0000_00C8);
        bus(1'b0, ca(0, CH_COUNT), 32'h0);
        check("count range", 32'h1, 32'(rd[15:0] < 16'd200));
        repeat (220) @(posedge hclk);
        rchk("period new", ca(0, CH_PERIOD), 32'h0000_0078);
        bus(1'b1, OFF_DIS, 32'h1);
        $display("test update done");
    endtask
    task automatic t_flags();
        bus(1'b0, OFF_ISR, 32'h0);
        bus(1'b1, OFF_IER, 32'h4);
        cfg(2, md(4'h0, 1'b0, 1'b0, 1'b0), 5, 2);
        repeat (20) @(negedge hclk);
        check("irq on", 32'h1, 32'(irq));
        bus(1'b1, OFF_DIS, 32'h4);
        rchk("flags", OFF_ISR, 32'h4);
        rchk("flags clr", OFF_ISR, 32'h0);
        repeat (3) @(negedge hclk);
        check("irq off", 32'h0, 32'(irq));
        $display("test flags done");
    endtask
    task automatic t_count();
        cfg(3, md(4'h0, 1'b0, 1'b0, 1'b0), 1000, 10);
        repeat (300) @(posedge hclk);
        bus(1'b1, OFF_DIS, 32'h8);
        bus(1'b0, ca(3, CH_COUNT), 32'h0);
        check("count held", 32'h1, 32'(rd != 32'h0));
        // a reserved select freezes the counter, so the clear shows exactly
        bus(1'b1, ca(3, CH_MODE), md(4'hD, 1'b0, 1'b0, 1'b0));
        bus(1'b1, OFF_ENA, 32'h8);
        rchk("count clr", ca(3, CH_COUNT), 32'h0);
        // divider a off freezes the counter, factor 1 passes the master clock on
        bus(1'b1, OFF_CLK_DIV, 32'h0000_0000);
        bus(1'b1, ca(3, CH_MODE), md(4'hB, 1'b0, 1'b0, 1'b0));
        repeat (40) @(posedge hclk);
        rchk("count off", ca(3, CH_COUNT), 32'h0);
        bus(1'b1, OFF_CLK_DIV, 32'h0000_0001);
        bus(1'b0, ca(3, CH_COUNT), 32'h0);
        check("count pass", 32'h1, 32'(rd != 32'h0));
        bus(1'b1, OFF_DIS, 32'h8);
        $display("test count done");
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_mask();
        t_wave();
        t_update();
        t_flags();
        t_count();
        wrap_up();
    end
endmodule

//--- hdl/pwm_block.sv
// Purpose: four-channel pulse-width modulator with ahb-lite registers
// Assumes: 20 MHz hclk, single word accesses, OKAY responses only
// Notes: zero-wait-state slave; write data applied at data phase edge
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
// Operation
// R1: mask register shows per-channel interrupt enables
// R2: period flag set on each completed period
// R3: reading status returns flags and clears them
// R4: select field picks power prescale or A/B
// R5: alignment bit: 0 left, 1 centre
// R6: polarity bit sets period start level
// R7: target 0: update loads duty at period start
// R8: target 1: update loads period at period start
// R9: only low 16 bits of values used
// R10: software keeps duty within period
// R11: left period equals period times factor
// R12: centre period equals twice period times factor
// R13: counter cleared when channel enabled
// R14: left counter clears on reaching period
// R15: update register double-buffers changes
// R16: divider 0 off, 1 pass, else divide
// R17: enable write sets mask bits only
// R18: centre counter goes up then down
// R19: interrupt asserted on flagged unmasked channel
// R20: output toggles on duty match, resets at start
module pwm_block
    import pwm_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // waveform and interrupt
    output logic [NUM_CH-1:0] pwm_out,
    output logic irq
);
    tick_if ticks ();

    // ======================================================
    // bus address phase capture
    logic wr_pend_q;
    logic [11:0] addr_q;
    logic [31:0] rdata_q;
    logic [31:0] clk_div_q;
    logic [NUM_CH-1:0] ena_q;
    logic [NUM_CH-1:0] mask_q;
    logic [NUM_CH-1:0] flag_q;
    logic [10:0] mode_q [NUM_CH];
    cnt_t duty_q [NUM_CH];
    cnt_t period_q [NUM_CH];
    cnt_t upd_q [NUM_CH];
    logic [NUM_CH-1:0] upd_pend_q;
    cnt_t cnt_q [NUM_CH];
    logic [NUM_CH-1:0] down_q;
    logic [NUM_CH-1:0] out_q;
    logic [NUM_CH-1:0] ch_tick;
    logic [NUM_CH-1:0] period_end;
    logic [NUM_CH-1:0] ena_set;
    logic [NUM_CH-1:0] ena_clr;
    logic take;
    logic [31:0] rd_mux;
    logic isr_read;
    logic ch_hit;
    logic [1:0] ch_idx;
    logic [2:0] ch_reg;
    logic [31:0] div_wr;
    logic [10:0] mode_wr;
    logic irq_any;

    assign take = hsel && hready && htrans[1];
    assign ch_hit = (addr_q[11:9] == 3'b001) && (addr_q[8:7] == 2'b00);
    assign ch_idx = addr_q[6:5];
    assign ch_reg = addr_q[4:2];

    // a wait state from another slave holds the captured phase in place
    // reads are taken at the address edge, so a read right behind a write to the
    // same register still returns the old value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q <= 12'h000;
        end else if (hready) begin
            wr_pend_q <= take && hwrite;
            addr_q <= haddr;
        end
    end

    function automatic logic wr_to(input logic w, input logic [11:0] a, input logic [11:0] off);
        wr_to = w && (a == off);
    endfunction

    // ======================================================
    // read mux, taken in address phase so data stands in data phase
    logic [1:0] ra_ch;
    logic [2:0] ra_reg;
    logic ra_chan;
    assign ra_ch = haddr[6:5];
    assign ra_reg = haddr[4:2];
    assign ra_chan = (haddr[11:9] == 3'b001) && (haddr[8:7] == 2'b00);

    always_comb begin
        rd_mux = RESET_ZERO;
        if (haddr == OFF_CLK_DIV) begin
            rd_mux = clk_div_q;
        end else if (haddr == OFF_SR) begin
            rd_mux[NUM_CH-1:0] = ena_q;
        end else if (haddr == OFF_IMR) begin
            rd_mux[NUM_CH-1:0] = mask_q; // [R1]
        end else if (haddr == OFF_ISR) begin
            rd_mux[NUM_CH-1:0] = flag_q; // [R3]
        end else if (ra_chan && ra_reg == CH_MODE) begin
            rd_mux[10:0] = mode_q[ra_ch];
        end else if (ra_chan && ra_reg == CH_DUTY) begin
            rd_mux[CNT_W-1:0] = duty_q[ra_ch];
        end else if (ra_chan && ra_reg == CH_PERIOD) begin
            rd_mux[CNT_W-1:0] = period_q[ra_ch];
        end else if (ra_chan && ra_reg == CH_COUNT) begin
            rd_mux[CNT_W-1:0] = cnt_q[ra_ch];
        end
    end

    // the status read clears the flags at the address edge, after the mux took them
    assign isr_read = take && !hwrite && (haddr == OFF_ISR);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) rdata_q <= RESET_ZERO;
        else if (take && !hwrite) rdata_q <= rd_mux;
    end

    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ======================================================
    // global control registers
    assign ena_set = wr_to(wr_pend_q, addr_q, OFF_ENA) ? hwdata[NUM_CH-1:0] : '0;
    assign ena_clr = wr_to(wr_pend_q, addr_q, OFF_DIS) ? hwdata[NUM_CH-1:0] : '0;

    // reserved bits are dropped on the way in so they always read back as zero
    assign div_wr = {4'h0, hwdata[DIVIDER_B_SOURCE_LSB+:4], hwdata[DIVIDER_B_FACTOR_LSB+:8],
        4'h0, hwdata[DIVIDER_A_SOURCE_LSB+:4], hwdata[DIVIDER_A_FACTOR_LSB+:8]};
    assign mode_wr = {hwdata[MODE_TGT_BIT], hwdata[MODE_POL_BIT], hwdata[MODE_ALIGN_BIT],
        4'h0, hwdata[MODE_SEL_LSB+:4]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_div_q <= RESET_ZERO;
            ena_q <= '0;
            mask_q <= '0;
        end else begin
            if (wr_to(wr_pend_q, addr_q, OFF_CLK_DIV)) clk_div_q <= div_wr;
            ena_q <= (ena_q & ~ena_clr) | ena_set;
            if (wr_to(wr_pend_q, addr_q, OFF_IER)) begin
                mask_q <= mask_q | hwdata[NUM_CH-1:0]; // [R17]
            end else if (wr_to(wr_pend_q, addr_q, OFF_IDR)) begin
                mask_q <= mask_q & ~hwdata[NUM_CH-1:0];
            end
        end
    end

    // ======================================================
    // interrupt flags
    // flags: a period end in the clearing cycle survives the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= '0;
        end else begin
            flag_q <= (isr_read ? '0 : flag_q) | period_end; // [R2] [R3]
        end
    end

    // irq trails the flag by one cycle so the output comes straight from a flop
    assign irq_any = |(flag_q & mask_q);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) irq <= 1'b0;
        else irq <= irq_any; // [R19]
    end

    // ======================================================
    // prescaler and dividers a and b
    pwm_clk_div u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .div_a(clk_div_q[DIVIDER_A_FACTOR_LSB+:8]),
        .src_a(clk_div_q[DIVIDER_A_SOURCE_LSB+:4]),
        .div_b(clk_div_q[DIVIDER_B_FACTOR_LSB+:8]),
        .src_b(clk_div_q[DIVIDER_B_SOURCE_LSB+:4]),
        .ticks(ticks.src)
    );

    // ======================================================
    // channels
    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_ch
            logic [3:0] sel;
            logic align;
            logic pol;
            logic tgt;
            logic wr_ch;
            logic at_top;
            logic at_zero;
            logic wr_mode;
            logic wr_duty;
            logic wr_period;
            logic wr_upd;
            assign sel = mode_q[c][MODE_SEL_LSB+:4];
            assign align = mode_q[c][MODE_ALIGN_BIT];
            assign pol = mode_q[c][MODE_POL_BIT];
            assign tgt = mode_q[c][MODE_TGT_BIT];
            assign wr_ch = wr_pend_q && ch_hit && (ch_idx == 2'(c));
            // one strobe per writable channel register (count has none), all from the data-phase edge
            assign wr_mode = wr_ch && (ch_reg == CH_MODE);
            assign wr_duty = wr_ch && (ch_reg == CH_DUTY);
            assign wr_period = wr_ch && (ch_reg == CH_PERIOD);
            assign wr_upd = wr_ch && (ch_reg == CH_UPDATE);
            // reserved select codes leave the counter stopped
            assign ch_tick[c] = ena_q[c] && (
                (sel <= SEL_MAX_POW) ? ticks.pow_tick[sel] :
                (sel == SEL_CLK_A) ? ticks.tick_a :
                (sel == SEL_CLK_B) ? ticks.tick_b : 1'b0); // [R4]
            assign at_top = (cnt_q[c] + 16'h0001 >= period_q[c]);
            assign at_zero = (cnt_q[c] <= 16'h0001);
            // left: counts 0..period-1, period ticks per cycle [R11] [R14]
            // centre: counts up to period, back down to 0 [R12] [R18]
            assign period_end[c] = ch_tick[c] &&
                (align ? (down_q[c] && at_zero) : at_top); // [R5]

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    mode_q[c] <= 11'h000;
                    duty_q[c] <= 16'h0000;
                    period_q[c] <= 16'h0000;
                    upd_q[c] <= 16'h0000;
                    upd_pend_q[c] <= 1'b0;
                end else begin
                    if (wr_mode) mode_q[c] <= mode_wr;
                    if (wr_duty) duty_q[c] <= hwdata[CNT_W-1:0]; // [R9]
                    if (wr_period) period_q[c] <= hwdata[CNT_W-1:0]; // [R9]
                    // a second update before the period ends replaces the first
                    if (wr_upd) begin
                        upd_q[c] <= hwdata[CNT_W-1:0]; // [R9] [R15]
                        upd_pend_q[c] <= 1'b1;
                    end else if (period_end[c] && upd_pend_q[c]) begin
                        upd_pend_q[c] <= 1'b0;
                        if (tgt) period_q[c] <= upd_q[c]; // [R8]
                        else duty_q[c] <= upd_q[c]; // [R7]
                    end
                end
            end

            // left mode wraps at period-1 so the period is exact; the trade is that
            // the count never reads back as the period value itself
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cnt_q[c] <= 16'h0000;
                    down_q[c] <= 1'b0;
                end else if (ena_set[c]) begin
                    cnt_q[c] <= 16'h0000; // [R13]
                    down_q[c] <= 1'b0;
                end else if (ch_tick[c]) begin
                    if (!align) begin
                        cnt_q[c] <= at_top ? 16'h0000 : cnt_q[c] + 16'h0001; // [R14]
                        down_q[c] <= 1'b0;
                    end else if (!down_q[c]) begin
                        cnt_q[c] <= cnt_q[c] + 16'h0001; // [R18]
                        down_q[c] <= at_top;
                    end else begin
                        cnt_q[c] <= cnt_q[c] - 16'h0001; // [R18]
                        down_q[c] <= !at_zero;
                    end
                end
            end

            // start level at period start, opposite once counter reaches duty
            // a disabled channel rests at its start level
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    out_q[c] <= 1'b0;
                end else if (!ena_q[c]) begin
                    out_q[c] <= pol; // [R6]
                end else if (cnt_q[c] == 16'h0000 && !down_q[c]) begin
                    out_q[c] <= (duty_q[c] == 16'h0000) ? !pol : pol; // [R6] [R20]
                end else if (cnt_q[c] >= duty_q[c]) begin
                    out_q[c] <= !pol; // [R20]
                end else begin
                    out_q[c] <= pol;
                end
            end
        end
    endgenerate

    assign pwm_out = out_q;
endmodule

//--- hdl/pwm_clk_div.sv
// Purpose: master clock prescaler and the two programmable dividers
// Assumes: one clock, ticks are one-cycle enables
// Notes: bit k of pow_tick pulses once every 2**k cycles
`timescale 1ns/10ps
module pwm_clk_div
    import pwm_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // divider settings
    input wire logic [7:0] div_a,
    input wire logic [3:0] src_a,
    input wire logic [7:0] div_b,
    input wire logic [3:0] src_b,
    // ticks out
    tick_if.src ticks
);
    logic [9:0] pre_q;
    logic [7:0] cnt_a_q;
    logic [7:0] cnt_b_q;
    logic [10:0] pow;
    logic src_a_tick;
    logic src_b_tick;

    // ======================================================
    // prescaler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) pre_q <= 10'h000;
        else pre_q <= pre_q + 10'h001;
    end

    assign pow[0] = 1'b1;
    genvar k;
    generate
        for (k = 1; k < 11; k++) begin : g_pow
            assign pow[k] = (pre_q[k-1:0] == {k{1'b1}});
        end
    endgenerate
    assign ticks.pow_tick = pow;

    function automatic logic pick(input logic [10:0] p, input logic [3:0] s);
        pick = (s <= SEL_MAX_POW) ? p[s] : 1'b0;
    endfunction

    assign src_a_tick = pick(pow, src_a);
    assign src_b_tick = pick(pow, src_b);

    // ======================================================
    // dividers: factor 0 stops the clock, 1 passes the source through [R16]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_a_q <= 8'h00;
            cnt_b_q <= 8'h00;
        end else begin
            if (src_a_tick) cnt_a_q <= (cnt_a_q + 8'h01 >= div_a) ? 8'h00 : cnt_a_q + 8'h01;
            if (src_b_tick) cnt_b_q <= (cnt_b_q + 8'h01 >= div_b) ? 8'h00 : cnt_b_q + 8'h01;
        end
    end
    assign ticks.tick_a = src_a_tick && (div_a != 8'h00) && (cnt_a_q + 8'h01 >= div_a); // [R16]
    assign ticks.tick_b = src_b_tick && (div_b != 8'h00) && (cnt_b_q + 8'h01 >= div_b); // [R16]
endmodule

//--- pkg/pwm_pkg.sv
// Purpose: constants and types shared by the four-channel pwm block
// Assumes: ahb-lite register access, 32-bit words, 4 channels
// Notes: channel registers sit at 0x200 + ch*0x20
package pwm_pkg;
    localparam int NUM_CH = 4;
    localparam int CNT_W = 16;
    // global register byte offsets
    localparam logic [11:0] OFF_CLK_DIV = 12'h000;
    localparam logic [11:0] OFF_ENA = 12'h004;
    localparam logic [11:0] OFF_DIS = 12'h008;
    localparam logic [11:0] OFF_SR = 12'h00C;
    localparam logic [11:0] OFF_IER = 12'h010;
    localparam logic [11:0] OFF_IDR = 12'h014;
    localparam logic [11:0] OFF_IMR = 12'h018;
    localparam logic [11:0] OFF_ISR = 12'h01C;
    localparam logic [11:0] OFF_CH_BASE = 12'h200;
    localparam logic [2:0] CH_MODE = 3'h0;
    localparam logic [2:0] CH_DUTY = 3'h1;
    localparam logic [2:0] CH_PERIOD = 3'h2;
    localparam logic [2:0] CH_COUNT = 3'h3;
    localparam logic [2:0] CH_UPDATE = 3'h4;
    // mode field positions
    localparam int MODE_SEL_LSB = 0;
    localparam int MODE_ALIGN_BIT = 8;
    localparam int MODE_POL_BIT = 9;
    localparam int MODE_TGT_BIT = 10;
    localparam logic [3:0] SEL_MAX_POW = 4'hA;
    localparam logic [3:0] SEL_CLK_A = 4'hB;
    localparam logic [3:0] SEL_CLK_B = 4'hC;
    // clock divider register fields
    localparam int DIVIDER_A_FACTOR_LSB = 0;
    localparam int DIVIDER_A_SOURCE_LSB = 8;
    localparam int DIVIDER_B_FACTOR_LSB = 16;
    localparam int DIVIDER_B_SOURCE_LSB = 24;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    localparam logic [10:0] PRESCALE_W_ONES = 11'h7FF;
    typedef logic [CNT_W-1:0] cnt_t;
endpackage

//--- pkg/tick_if.sv
// Purpose: carries prescaler ticks from the clock divider to the channels
// Assumes: single clock domain
// Notes: all signals are one-cycle enables
`timescale 1ns/10ps
interface tick_if;
    logic [10:0] pow_tick;
    logic tick_a;
    logic tick_b;
    modport src (output pow_tick, output tick_a, output tick_b);
    modport dst (input pow_tick, input tick_a, input tick_b);
endinterface
